// ### design/drp_data_rom_read_port.v
// Summary of operation
// - the read address is the five address nibbles joined into one 20-bit byte address.
// - nibble register 0 is the least significant nibble and register 4 the most significant.
// - software waits two clock periods after the last address write; data is valid by then.
// - reading the low data register returns bits 3..0 of the addressed byte.
// - reading the high data register returns bits 7..4 of the addressed byte.
// - a write to the high data register restarts the watchdog when enabled and stores nothing.
// - memory entries are 8 bits wide over a 20-bit byte address space.
// - the seven registers occupy locations 18h..1Eh with the data registers at 1Ch and 1Dh.
`timescale 1ns/10ps
`default_nettype none
`include "drp_map.vh"
module drp_data_rom_read_port (
	// clock and reset
	input wire ref_clk_i,
	input wire arst_n_i,
	// special-register port from the core
	input wire [4:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [3:0] sfr_wdata_i,
	output wire [3:0] sfr_rdata_o,
	output wire sfr_hit_o,
	// watchdog option and restart
	input wire wdt_enable_i,
	output wire wdt_restart_o,
	// memory array port
	output wire [19:0] rom_addr_o,
	input wire [7:0] rom_data_i,
	// data valid status
	output wire rom_ready_o
);
	// one-hot states of the data-ready sequencer
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_READY = 3'h4;

	// address nibble values
	wire [3:0] nib0;
	wire [3:0] nib1;
	wire [3:0] nib2;
	wire [3:0] nib3;
	wire [3:0] nib4;
	// register selects and write strobes
	wire sel_nib0;
	wire sel_nib1;
	wire sel_nib2;
	wire sel_nib3;
	wire sel_nib4;
	wire sel_data_lo;
	wire sel_data_hi;
	wire sel_any;
	wire [4:0] nib_wr;
	wire addr_written;
	wire hi_written;
	// read path
	reg [3:0] rdata_reg;
	reg [3:0] rdata_next;
	reg hit_reg;
	reg hit_next;
	// watchdog restart pulse
	reg wdt_restart_reg;
	reg wdt_restart_next;
	// byte address and data-ready sequencer
	reg [19:0] rom_addr_reg;
	reg [19:0] rom_addr_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [1:0] wait_cnt_reg;
	reg [1:0] wait_cnt_next;
	reg ready_reg;
	reg ready_next;

	// only the seven locations answer; the rest of the nibble space is left alone
	assign sel_nib0 = (sfr_addr_i == `DRP_ADDR_NIB0);
	assign sel_nib1 = (sfr_addr_i == `DRP_ADDR_NIB1);
	assign sel_nib2 = (sfr_addr_i == `DRP_ADDR_NIB2);
	assign sel_nib3 = (sfr_addr_i == `DRP_ADDR_NIB3);
	assign sel_nib4 = (sfr_addr_i == `DRP_ADDR_NIB4);
	assign sel_data_lo = (sfr_addr_i == `DRP_DATA_LO);
	assign sel_data_hi = (sfr_addr_i == `DRP_DATA_HI);
	assign sel_any = sel_nib0 | sel_nib1 | sel_nib2 | sel_nib3 | sel_nib4
		| sel_data_lo | sel_data_hi;

	// address nibble write strobes
	assign nib_wr[0] = sfr_wr_i & sel_nib0;
	assign nib_wr[1] = sfr_wr_i & sel_nib1;
	assign nib_wr[2] = sfr_wr_i & sel_nib2;
	assign nib_wr[3] = sfr_wr_i & sel_nib3;
	assign nib_wr[4] = sfr_wr_i & sel_nib4;
	assign addr_written = |nib_wr;
	// the data registers have no storage; a write to the high one only pokes the watchdog
	assign hi_written = sfr_wr_i & sel_data_hi;

	// address registers keep their nibble across reset
	drp_nibble_reg #(.NIB_W(`DRP_NIB_W)) u_nib0 (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(nib_wr[0]),
		.wr_data_i(sfr_wdata_i),
		.q_o(nib0)
	);
	drp_nibble_reg #(.NIB_W(`DRP_NIB_W)) u_nib1 (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(nib_wr[1]),
		.wr_data_i(sfr_wdata_i),
		.q_o(nib1)
	);
	drp_nibble_reg #(.NIB_W(`DRP_NIB_W)) u_nib2 (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(nib_wr[2]),
		.wr_data_i(sfr_wdata_i),
		.q_o(nib2)
	);
	drp_nibble_reg #(.NIB_W(`DRP_NIB_W)) u_nib3 (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(nib_wr[3]),
		.wr_data_i(sfr_wdata_i),
		.q_o(nib3)
	);
	drp_nibble_reg #(.NIB_W(`DRP_NIB_W)) u_nib4 (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(nib_wr[4]),
		.wr_data_i(sfr_wdata_i),
		.q_o(nib4)
	);

	// byte address, highest nibble first; the reserved top area is not range checked
	always @* begin
		rom_addr_next = {nib4, nib3, nib2, nib1, nib0};
	end

	always @(posedge ref_clk_i) begin
		rom_addr_reg <= rom_addr_next;
	end

	// data-ready sequencer; idle after reset until any address nibble is first written,
	// so ready can rise while the unwritten nibbles are still undefined
	always @* begin
		state_next = state_reg;
		wait_cnt_next = wait_cnt_reg;
		ready_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				ready_next = 1'b0;
			end
			ST_WAIT: begin
				wait_cnt_next = wait_cnt_reg + 2'h1;
				if (wait_cnt_next == `DRP_READY_CNT_MAX) begin
					state_next = ST_READY;
					ready_next = 1'b1;
				end
			end
			ST_READY: begin
				ready_next = 1'b1;
			end
			default: begin
				state_next = ST_IDLE;
				wait_cnt_next = 2'h0;
			end
		endcase
		// any address nibble restarts the wait, whatever the state
		if (addr_written) begin
			state_next = ST_WAIT;
			wait_cnt_next = 2'h0;
			ready_next = 1'b0;
		end
	end

	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_IDLE;
			wait_cnt_reg <= 2'h0;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_cnt_reg <= wait_cnt_next;
			ready_reg <= ready_next;
		end
	end

	// read mux; data comes straight from the array so a read taken two clocks after
	// the last address write already returns the new byte
	always @* begin
		rdata_next = 4'h0;
		hit_next = 1'b0;
		if (sfr_rd_i) begin
			hit_next = sel_any;
			case (sfr_addr_i)
				`DRP_ADDR_NIB0: rdata_next = nib0;
				`DRP_ADDR_NIB1: rdata_next = nib1;
				`DRP_ADDR_NIB2: rdata_next = nib2;
				`DRP_ADDR_NIB3: rdata_next = nib3;
				`DRP_ADDR_NIB4: rdata_next = nib4;
				`DRP_DATA_LO: rdata_next = rom_data_i[3:0];
				`DRP_DATA_HI: rdata_next = rom_data_i[7:4];
				default: rdata_next = 4'h0;
			endcase
		end
	end

	// restart only while the watchdog option is on
	always @* begin
		wdt_restart_next = hi_written & wdt_enable_i;
	end

	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 4'h0;
			hit_reg <= 1'b0;
			wdt_restart_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			hit_reg <= hit_next;
			wdt_restart_reg <= wdt_restart_next;
		end
	end

	assign sfr_rdata_o = rdata_reg;
	assign sfr_hit_o = hit_reg;
	assign wdt_restart_o = wdt_restart_reg;
	assign rom_addr_o = rom_addr_reg;
	assign rom_ready_o = ready_reg;
endmodule // drp_data_rom_read_port
`default_nettype wire

// ### design/drp_map.vh
`ifndef DRP_MAP_VH
`define DRP_MAP_VH
// special-register locations (5-bit nibble address space)
`define DRP_ADDR_NIB0 5'h18
`define DRP_ADDR_NIB1 5'h19
`define DRP_ADDR_NIB2 5'h1A
`define DRP_ADDR_NIB3 5'h1B
`define DRP_DATA_LO 5'h1C
`define DRP_DATA_HI 5'h1D
`define DRP_ADDR_NIB4 5'h1E
// widths
`define DRP_ROM_AW 20
`define DRP_NIB_W 4
`define DRP_BYTE_W 8
// data ready time, in system clock periods
`define DRP_READY_CYCLES 2
`define DRP_READY_CNT_W 2
`define DRP_READY_CNT_MAX 2'h2
`endif

// ### design/drp_nibble_reg.v
`timescale 1ns/10ps
`default_nettype none
// one 4-bit address register; contents are not cleared by reset
`include "drp_map.vh"
module drp_nibble_reg #(
	parameter NIB_W = `DRP_NIB_W
) (
	// clock
	input wire ref_clk_i,
	// write port
	input wire wr_en_i,
	input wire [NIB_W-1:0] wr_data_i,
	// stored value
	output wire [NIB_W-1:0] q_o
);
	reg [NIB_W-1:0] q_reg;

	always @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			q_reg <= wr_data_i;
		end
	end

	assign q_o = q_reg;
endmodule // drp_nibble_reg
`default_nettype wire

// ### sim/drp_chk.sv
`timescale 1ns/10ps
`default_nettype none
module drp_chk (
	input wire logic ref_clk_i, arst_n_i, sfr_wr_i, sfr_rd_i, wdt_enable_i,
	input wire logic [4:0] sfr_addr_i,
	input wire logic [3:0] sfr_wdata_i, sfr_rdata_o,
	input wire logic sfr_hit_o, wdt_restart_o, rom_ready_o,
	input wire logic [19:0] rom_addr_o,
	input wire logic [7:0] rom_data_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	wire map = sfr_addr_i >= 5'h18 && sfr_addr_i <= 5'h1E;
	wire wr_hi = sfr_wr_i && sfr_addr_i == 5'h1D && wdt_enable_i;
	wire wr_top = sfr_wr_i && sfr_addr_i == 5'h1E;
	wire wr_addr = sfr_wr_i && map && sfr_addr_i != 5'h1C && sfr_addr_i != 5'h1D;
	a_low_data: assert property (sfr_rd_i && sfr_addr_i == 5'h1C
		|=> sfr_rdata_o == $past(rom_data_i[3:0])) else $error("low nibble");
	a_high_data: assert property (sfr_rd_i && sfr_addr_i == 5'h1D
		|=> sfr_rdata_o == $past(rom_data_i[7:4])) else $error("high nibble");
	a_wdt_pulse: assert property (wr_hi |=> wdt_restart_o) else $error("no restart");
	a_wdt_quiet: assert property (!wr_hi |=> !wdt_restart_o) else $error("restart");
	a_ready_due: assert property (wr_top ##1 !sfr_wr_i [*2] |=> rom_ready_o)
		else $error("late data");
	a_ready_drop: assert property (wr_addr |=> !rom_ready_o) else $error("stale ready");
	a_top_nibble: assert property (wr_top |-> ##2 rom_addr_o[19:16] == $past(sfr_wdata_i, 2))
		else $error("address order");
	a_map_hit: assert property (sfr_rd_i |=> sfr_hit_o == $past(map)) else $error("hit");
	a_unmapped_zero: assert property (sfr_rd_i && !map |=> sfr_rdata_o == 4'h0)
		else $error("unmapped data");
	c_restart: cover property (wdt_restart_o);
	c_ready: cover property (rom_ready_o);
	c_hit: cover property (sfr_hit_o);
endmodule // drp_chk
bind drp_data_rom_read_port drp_chk drp_chk_inst (.ref_clk_i, .arst_n_i, .sfr_wr_i, .sfr_rd_i,
	.wdt_enable_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .wdt_restart_o,
	.rom_ready_o, .rom_addr_o, .rom_data_i);
`default_nettype wire

// ### sim/drp_rom_model.sv
`timescale 1ns/10ps
`default_nettype none
module drp_rom_model (
	input wire logic [19:0] rom_addr_i,
	output logic [7:0] rom_data_o
);
	// pattern mixes both address ends so a nibble swap changes the byte unless it pairs nibble 0 with 3 or 1 with 4
	assign rom_data_o = rom_addr_i[7:0] ^ rom_addr_i[19:12];
endmodule // drp_rom_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk_i = 1'h0, arst_n_i = 1'h0, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
	logic wdt_enable_i = 1'h0, h, r, y;
	logic [4:0] sfr_addr_i = 5'h00;
	logic [3:0] sfr_wdata_i = 4'h0, q, sfr_rdata_o;
	logic [7:0] b, rom_data_i;
	logic [19:0] rom_addr_o;
	logic sfr_hit_o, wdt_restart_o, rom_ready_o;
	int err_count = 0, checks_done = 0;
	drp_data_rom_read_port drp_data_rom_read_port_inst (.ref_clk_i, .arst_n_i, .sfr_addr_i,
		.sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .wdt_enable_i,
		.wdt_restart_o, .rom_addr_o, .rom_data_i, .rom_ready_o);
	drp_rom_model drp_rom_model_inst (.rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	task automatic finish_test;
		if (err_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one strobe cycle; results sampled once the answering edge has landed
	task automatic acc(input logic w, input logic [4:0] a, input logic [3:0] d);
		@(posedge ref_clk_i);
		{sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} <= {w, !w, a, d};
		@(posedge ref_clk_i);
		{sfr_wr_i, sfr_rd_i} <= 2'h0;
		#1 {q, h, r, y} = {sfr_rdata_o, sfr_hit_o, wdt_restart_o, rom_ready_o};
	endtask
	// reads start exactly two cycles after the last nibble write when n is above 0
	task automatic rw(input logic [19:0] a, input int n);
		for (int i = 0; i < n; i++) acc(1'h1, 5'(i < 4 ? 8'h18 + i : 8'h1E), a[4 * i +: 4]);
		if (n > 0) chk(y, 8'h00);
		acc(1'h0, 5'h1D, 4'h0);
		b[7:4] = q;
		chk(y, 8'h01);
		acc(1'h0, 5'h1C, 4'h0);
		b[3:0] = q;
		chk(b, a[7:0] ^ a[19:12]);
	endtask
	task automatic t_bytes;
		rw(20'h12345, 5);
		rw(20'hA5C3E, 5);
		rw(20'hFFFBF, 5);
		rw(20'hFFFB7, 1);
	endtask
	task automatic t_map;
		acc(1'h0, 5'h1E, 4'h0);
		chk({h, q}, 8'h1F);
		acc(1'h0, 5'h1F, 4'h0);
		chk({h, q}, 8'h00);
		acc(1'h0, 5'h17, 4'h0);
		chk({h, q}, 8'h00);
	endtask
	task automatic t_wdt;
		@(posedge ref_clk_i);
		wdt_enable_i <= 1'h1;
		acc(1'h1, 5'h1D, 4'hA);
		chk(r, 8'h01);
		@(posedge ref_clk_i);
		wdt_enable_i <= 1'h0;
		acc(1'h1, 5'h1D, 4'h5);
		chk(r, 8'h00);
		rw(20'hFFFB7, 0);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_i);
		arst_n_i <= 1'h1;
		t_bytes;
		t_map;
		t_wdt;
		finish_test;
	end
	initial begin
		#20000;
		err_count++;
		finish_test;
	end
endmodule // tb
`default_nettype wire
